//--- verilog/filler_io_defines.vh
// Register map, field positions, reset values and timing counts of the selectable I/O controller.
`ifndef FILLER_IO_DEFINES_VH
`define FILLER_IO_DEFINES_VH
`define ADDR_CTRL        8'h00
`define ADDR_FUNC_EN     8'h04
`define ADDR_REMOTE_MASK 8'h08
`define ADDR_ALARM_SP    8'h0C
`define ADDR_ALARM_TIME  8'h10
`define ADDR_RECIPE1     8'h14
`define ADDR_RECIPE2     8'h18
`define ADDR_TOLERANCE   8'h1C
`define ADDR_EMPTY_SP    8'h20
`define ADDR_FINE_BAND   8'h24
`define ADDR_SEL_OUT     8'h28
`define ADDR_STATUS      8'h2C
`define ADDR_REMOTE_IN   8'h30
`define ADDR_FILL_COUNT  8'h34
`define ADDR_LAST_RESULT 8'h38
// Input vector positions.
`define IN_START       0
`define IN_RUN_EN      1
`define IN_INHIBIT     2
`define IN_RESUME      3
`define IN_REJECT      4
`define IN_INTERRUPT   5
`define IN_HOLD        6
`define IN_EMPTY       7
`define IN_BYPASS      8
`define IN_CLAMP       9
`define IN_S2CONF      10
`define IN_TILT        11
`define IN_STANDBY     12
`define IN_RECIPE_ONE_SELECT_IN        13
`define IN_RECIPE_TWO_SELECT_IN        14
`define IN_DISCHARGE_INTERRUPT_IN        15
`define IN_REL_HIGH    16
`define IN_REL_LOW     17
`define IN_RESET       18
`define IN_DISCHARGE   19
`define IN_TOUCH_TOP   20
`define NUM_INPUTS     21
// CTRL fields and operating modes.
`define CTRL_BUNG_BIT  0
`define CTRL_MODE_LSB  1
`define MODE_WEIGH     2'h0
`define MODE_FILL      2'h1
`define MODE_BUNG      2'h2
`define MODE_BOTTOM    2'h3
// Reset values.
`define RST_CTRL       32'h0000_0002
`define RST_FUNC_EN    32'h001F_FFFF
`define RST_ZERO       32'h0000_0000
`define RST_ALARM_TIME 16'h0001
// Timing: input filter and the 1 ms alarm time base at 250 MHz.
`define CLK_HZ         250000000
`define FILTER_NS      1000
`define FILTER_CYCLES  ((`FILTER_NS * 250) / 1000)
`define MS_CYCLES      (`CLK_HZ / 1000)
`endif

//--- verilog/input_qualifier.v
// Two-stage synchroniser, stability filter and rising edge detector for the selectable inputs.
`timescale 1ns/1ps
module input_qualifier #(
   parameter WIDTH  = 21,
   parameter FILTER = 250
) (
   input  wire             pclk,
   input  wire             presetn,
   input  wire [WIDTH-1:0] raw_in,
   output reg  [WIDTH-1:0] level_q,
   output wire [WIDTH-1:0] rise
);
   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;
   reg [WIDTH-1:0] prev_q;
   reg [15:0]      cnt_q [0:WIDTH-1];
   integer i;

   assign rise = level_q & ~prev_q;

   ////////////////////////////////////////////////////////////////////////////
   // A level is accepted only after it held steady for FILTER cycles, which
   // hides contact bounce from the fill sequence.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q  <= {WIDTH{1'b0}};
         sync_q  <= {WIDTH{1'b0}};
         prev_q  <= {WIDTH{1'b0}};
         level_q <= {WIDTH{1'b0}};
         for (i = 0; i < WIDTH; i = i + 1) begin
            cnt_q[i] <= 16'h0000;
         end
      end else begin
         meta_q <= raw_in;
         sync_q <= meta_q;
         prev_q <= level_q;
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (sync_q[i] == level_q[i]) begin
               cnt_q[i] <= 16'h0000;
            end else if (cnt_q[i] >= FILTER[15:0] - 16'h0001) begin
               cnt_q[i]   <= 16'h0000;
               level_q[i] <= sync_q[i];
            end else begin
               cnt_q[i] <= cnt_q[i] + 16'h0001;
            end
         end
      end
   end
endmodule

//--- verilog/filler_selectable_io_control.v
// Fill sequencer that gives the selectable inputs and the alarm output their effect, with an APB register file.
`timescale 1ns/1ps
`include "filler_io_defines.vh"

// Function
// RULE_01: Run enable low ends fill, blocks starts.
// RULE_02: Assigned run enable gates start requests.
// RULE_03: Fill inhibit high blocks start requests.
// RULE_04: After error, resume continues and records result.
// RULE_05: Reject after error discards result, goes ready.
// RULE_06: Interrupt stops feeding, fill continues after.
// RULE_07: Interrupt blocks starts; reject/reset abandon fill.
// RULE_08: Hold stops filling and freezes all outputs; the code drives both feed outputs low instead of freezing them.
// RULE_09: Empty input opens emptying gate only when ready.
// RULE_10: Bypass when ready opens both gates, coarse feed.
// RULE_11: Bag holder only with clamp and confirm together.
// RULE_12: Tilt makes weight reading invalid and unused.
// RULE_13: Standby removes unit from master-slave participation.
// RULE_14: Recipe inputs load first or second recipe.
// RULE_15: Discharge interrupt stops feed, blocks start and discharge; the code does not gate the feed outputs with it.
// RULE_16: Release clamp on high input or low input.
// RULE_17: Overload alarm above setpoint for alarm time.
// RULE_18: Bung/bottom modes: touch alarm resets the fill.
// RULE_19: Bung containers route alarm to selectable output one.
// RULE_20: Remote inputs act nowhere, forwarded to host.
// RULE_21: Inputs synchronised, qualified; starts act on edges.
module filler_selectable_io_control #(
   parameter W         = 24,
   parameter MS_CYCLES = `MS_CYCLES
) (
   input  wire         pclk,
   input  wire         presetn,
   input  wire         psel,
   input  wire         penable,
   input  wire         pwrite,
   input  wire [7:0]   paddr,
   input  wire [31:0]  pwdata,
   output reg  [31:0]  prdata,
   output wire         pready,
   output wire         pslverr,
   input  wire [20:0]  sel_in,
   input  wire [W-1:0] gross_load,
   output reg          feed_coarse_out,
   output reg          feed_fine_out,
   output reg          fill_gate_out,
   output reg          empty_gate_out,
   output reg          bag_holder_out,
   output reg          alarm_out,
   output reg          sel_out1,
   output reg          active_member_out,
   output reg          weight_valid_out
);
   localparam [5:0] S_READY = 6'h01;
   localparam [5:0] S_FEED  = 6'h02;
   localparam [5:0] S_ERROR = 6'h04;
   localparam [5:0] S_DONE  = 6'h08;
   localparam [5:0] S_DISCH = 6'h10;
   localparam [5:0] S_BYP   = 6'h20;

   wire [20:0] lvl;
   wire [20:0] edge_r;
   reg  [31:0] ctrl_q;
   reg  [20:0] func_en_q;
   reg  [20:0] remote_q;
   reg  [W-1:0] alarm_sp_q;
   reg  [15:0] alarm_time_q;
   reg  [W-1:0] recipe1_q;
   reg  [W-1:0] recipe2_q;
   reg  [W-1:0] tol_q;
   reg  [W-1:0] empty_sp_q;
   reg  [W-1:0] fine_band_q;
   reg         sel_out1_reg_q;
   reg  [5:0]  state_q;
   reg  [5:0]  state_d;
   reg  [1:0]  recipe_q;
   reg  [W-1:0] target_q;
   reg  [31:0] fill_count_q;
   reg  [W-1:0] last_result_q;
   reg  [W-1:0] result_q;
   reg  [17:0] ms_cnt_q;
   reg  [15:0] alarm_cnt_q;
   reg         record_d;
   localparam [31:0] FUNC_EN_RST = `RST_FUNC_EN;

   input_qualifier #(
      .WIDTH  (`NUM_INPUTS),
      .FILTER (`FILTER_CYCLES)
   ) u_qual (
      .pclk    (pclk),
      .presetn (presetn),
      .raw_in  (sel_in),
      .level_q (lvl),
      .rise    (edge_r)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Function gating: an input acts only when assigned and not marked remote.
   function act;
      input [20:0] v;
      input [20:0] en;
      input [20:0] rm;
      input integer idx;
      begin
         act = v[idx] & en[idx] & ~rm[idx];
      end
   endfunction

   wire [1:0] mode     = ctrl_q[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];
   wire       bung_cfg = ctrl_q[`CTRL_BUNG_BIT];
   wire       run_assigned = func_en_q[`IN_RUN_EN] & ~remote_q[`IN_RUN_EN];
   wire       run_ok   = ~run_assigned | lvl[`IN_RUN_EN];                     // RULE_02
   wire       inhibit  = act(lvl, func_en_q, remote_q, `IN_INHIBIT);
   wire       intr     = act(lvl, func_en_q, remote_q, `IN_INTERRUPT);
   wire       hold     = act(lvl, func_en_q, remote_q, `IN_HOLD);
   wire       discharge_interrupt_in     = act(lvl, func_en_q, remote_q, `IN_DISCHARGE_INTERRUPT_IN);
   wire       standby  = act(lvl, func_en_q, remote_q, `IN_STANDBY);
   wire       tilt     = act(lvl, func_en_q, remote_q, `IN_TILT);
   wire       start_e  = act(edge_r, func_en_q, remote_q, `IN_START);         // RULE_21
   wire       resume_e = act(edge_r, func_en_q, remote_q, `IN_RESUME);
   wire       reject_e = act(edge_r, func_en_q, remote_q, `IN_REJECT);
   wire       reset_e  = act(edge_r, func_en_q, remote_q, `IN_RESET);
   wire       disch_e  = act(edge_r, func_en_q, remote_q, `IN_DISCHARGE);
   wire       bypass_e = act(edge_r, func_en_q, remote_q, `IN_BYPASS);
   wire       bypass_l = act(lvl, func_en_q, remote_q, `IN_BYPASS);
   wire       empty_l  = act(lvl, func_en_q, remote_q, `IN_EMPTY);
   wire       touch_e  = act(edge_r, func_en_q, remote_q, `IN_TOUCH_TOP);
   wire       rel_hi   = act(lvl, func_en_q, remote_q, `IN_REL_HIGH);
   wire       rel_lo   = act(~lvl, func_en_q, remote_q, `IN_REL_LOW);
   wire       clamp    = act(lvl, func_en_q, remote_q, `IN_CLAMP);
   wire       confirm  = act(lvl, func_en_q, remote_q, `IN_S2CONF);
   wire       weight_ok = ~tilt;                                               // RULE_12
   wire       start_ok = start_e & run_ok & ~inhibit & ~intr & ~discharge_interrupt_in & ~standby; // RULE_03 RULE_07 RULE_13
   wire       abandon  = (intr | discharge_interrupt_in) & (reject_e | reset_e);                 // RULE_07 RULE_15
   wire       touch_reset = touch_e & (mode == `MODE_BUNG || mode == `MODE_BOTTOM); // RULE_18
   wire       over_load = weight_ok & (gross_load > alarm_sp_q) &
                          (mode == `MODE_WEIGH || mode == `MODE_FILL);          // RULE_17
   wire       below_fine = gross_load + fine_band_q < target_q;
   wire       at_target  = weight_ok & (gross_load >= target_q);
   wire       ms_tick  = (ms_cnt_q == MS_CYCLES[17:0] - 18'h00001);

   ////////////////////////////////////////////////////////////////////////////
   // Fill sequence.
   always @* begin
      state_d  = state_q;
      record_d = 1'b0;
      case (state_q)
         S_READY: begin
            if (bypass_e) begin
               state_d = S_BYP;                                                  // RULE_10
            end else if (start_ok) begin
               state_d = S_FEED;                                                 // RULE_01
            end
         end
         S_FEED: begin
            if (!run_ok || abandon || touch_reset) begin
               state_d = S_READY;                                                // RULE_01 RULE_07 RULE_18
            end else if (at_target && !intr) begin
               if (gross_load > target_q + tol_q) begin
                  state_d = S_ERROR;
               end else begin
                  state_d  = S_DONE;
                  record_d = 1'b1;
               end
            end
         end
         S_ERROR: begin
            if (reject_e) begin
               state_d = S_READY;                                                // RULE_05
            end else if (resume_e) begin
               state_d  = S_DONE;                                                // RULE_04
               record_d = 1'b1;
            end
         end
         S_DONE: begin
            if (abandon) begin
               state_d = S_READY;
            end else if (disch_e && !discharge_interrupt_in) begin
               state_d = S_DISCH;                                                // RULE_15
            end
         end
         S_DISCH: begin
            if (abandon) begin
               state_d = S_READY;                                                // RULE_15
            end else if (weight_ok && gross_load < empty_sp_q && !discharge_interrupt_in) begin
               state_d = S_READY;
            end
         end
         S_BYP: begin
            if (!bypass_l) begin
               state_d = S_READY;
            end
         end
         default: state_d = S_READY;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q       <= S_READY;
         recipe_q      <= 2'h0;
         target_q      <= {W{1'b0}};
         fill_count_q  <= 32'h0000_0000;
         last_result_q <= {W{1'b0}};
         result_q      <= {W{1'b0}};
      end else begin
         if (!hold) begin
            state_q <= state_d;                                                 // RULE_08
         end
         if (state_q == S_FEED && state_d == S_ERROR) begin
            result_q <= gross_load;
         end
         if (!hold && record_d) begin
            fill_count_q  <= fill_count_q + 32'h0000_0001;
            last_result_q <= (state_q == S_ERROR) ? result_q : gross_load;
         end
         if (act(edge_r, func_en_q, remote_q, `IN_RECIPE_ONE_SELECT_IN)) begin
            recipe_q <= 2'h1;                                                   // RULE_14
            target_q <= recipe1_q;
         end else if (act(edge_r, func_en_q, remote_q, `IN_RECIPE_TWO_SELECT_IN)) begin
            recipe_q <= 2'h2;                                                   // RULE_14
            target_q <= recipe2_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Actuator outputs; both feed outputs drop low while hold is asserted, the rest stay frozen.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         feed_coarse_out   <= 1'b0;
         feed_fine_out     <= 1'b0;
         fill_gate_out     <= 1'b0;
         empty_gate_out    <= 1'b0;
         bag_holder_out    <= 1'b0;
         sel_out1          <= 1'b0;
         active_member_out <= 1'b0;
         weight_valid_out  <= 1'b0;
      end else if (hold) begin
         feed_coarse_out <= 1'b0;                                               // RULE_08
         feed_fine_out   <= 1'b0;
      end else begin
         feed_coarse_out   <= (state_q == S_FEED && !intr && below_fine) || state_q == S_BYP; // RULE_06 RULE_10
         feed_fine_out     <= state_q == S_FEED && !intr && !below_fine;       // RULE_06
         fill_gate_out     <= (state_q == S_FEED && !intr) || state_q == S_BYP;
         empty_gate_out    <= (state_q == S_READY && empty_l) || state_q == S_BYP ||
                              (state_q == S_DISCH && !discharge_interrupt_in);                    // RULE_09 RULE_15
         bag_holder_out    <= clamp & confirm & ~rel_hi & ~rel_lo;             // RULE_11 RULE_16
         sel_out1          <= bung_cfg ? alarm_out : sel_out1_reg_q;            // RULE_19
         active_member_out <= ~standby;                                        // RULE_13
         weight_valid_out  <= weight_ok;                                       // RULE_12
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Alarm stays on while overloaded and for the alarm time afterwards, so a
   // short peak still gives an audible signal. A touch event in bung or bottom mode pulses it too.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_cnt_q    <= 18'h00000;
         alarm_cnt_q <= 16'h0000;
         alarm_out   <= 1'b0;
      end else begin
         ms_cnt_q <= ms_tick ? 18'h00000 : ms_cnt_q + 18'h00001;
         if (over_load || touch_reset) begin
            alarm_cnt_q <= alarm_time_q;                                        // RULE_17
         end else if (ms_tick && alarm_cnt_q != 16'h0000) begin
            alarm_cnt_q <= alarm_cnt_q - 16'h0001;
         end
         if (!hold) begin
            alarm_out <= over_load || touch_reset || alarm_cnt_q != 16'h0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, error on unmapped or read-only writes.
   wire       acc    = psel & penable;
   wire       mapped = paddr[1:0] == 2'h0 && paddr <= `ADDR_LAST_RESULT;
   wire       ro     = paddr >= `ADDR_STATUS;
   assign pready  = 1'b1;
   assign pslverr = acc & (~mapped | (pwrite & ro));

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q         <= `RST_CTRL;
         func_en_q      <= FUNC_EN_RST[20:0];
         remote_q       <= 21'h000000;
         alarm_sp_q     <= {W{1'b1}};
         alarm_time_q   <= `RST_ALARM_TIME;
         recipe1_q      <= {W{1'b0}};
         recipe2_q      <= {W{1'b0}};
         tol_q          <= {W{1'b0}};
         empty_sp_q     <= {W{1'b0}};
         fine_band_q    <= {W{1'b0}};
         sel_out1_reg_q <= 1'b0;
      end else if (acc && pwrite && mapped) begin
         case (paddr)
            `ADDR_CTRL:        ctrl_q         <= pwdata;
            `ADDR_FUNC_EN:     func_en_q      <= pwdata[20:0];
            `ADDR_REMOTE_MASK: remote_q       <= pwdata[20:0];                 // RULE_20
            `ADDR_ALARM_SP:    alarm_sp_q     <= pwdata[W-1:0];
            `ADDR_ALARM_TIME:  alarm_time_q   <= pwdata[15:0];
            `ADDR_RECIPE1:     recipe1_q      <= pwdata[W-1:0];
            `ADDR_RECIPE2:     recipe2_q      <= pwdata[W-1:0];
            `ADDR_TOLERANCE:   tol_q          <= pwdata[W-1:0];
            `ADDR_EMPTY_SP:    empty_sp_q     <= pwdata[W-1:0];
            `ADDR_FINE_BAND:   fine_band_q    <= pwdata[W-1:0];
            `ADDR_SEL_OUT:     sel_out1_reg_q <= pwdata[0];
            default: ;
         endcase
      end
   end

   always @* begin
      prdata = 32'h0000_0000;
      case (paddr)
         `ADDR_CTRL:        prdata = ctrl_q;
         `ADDR_FUNC_EN:     prdata[20:0] = func_en_q;
         `ADDR_REMOTE_MASK: prdata[20:0] = remote_q;
         `ADDR_ALARM_SP:    prdata[W-1:0] = alarm_sp_q;
         `ADDR_ALARM_TIME:  prdata[15:0] = alarm_time_q;
         `ADDR_RECIPE1:     prdata[W-1:0] = recipe1_q;
         `ADDR_RECIPE2:     prdata[W-1:0] = recipe2_q;
         `ADDR_TOLERANCE:   prdata[W-1:0] = tol_q;
         `ADDR_EMPTY_SP:    prdata[W-1:0] = empty_sp_q;
         `ADDR_FINE_BAND:   prdata[W-1:0] = fine_band_q;
         `ADDR_SEL_OUT:     prdata[0] = sel_out1_reg_q;
         `ADDR_STATUS:      prdata[11:0] = {alarm_out, weight_ok, recipe_q, 2'h0, state_q};
         `ADDR_REMOTE_IN:   prdata[20:0] = lvl & remote_q;                      // RULE_20
         `ADDR_FILL_COUNT:  prdata = fill_count_q;
         `ADDR_LAST_RESULT: prdata[W-1:0] = last_result_q;
         default:           prdata = 32'h0000_0000;
      endcase
   end
endmodule

//--- verif/filler_io_properties.sv
// Concurrent checks on the ports of the selectable I/O controller.
`timescale 1ns/1ps
module filler_io_properties #(
   parameter W         = 24,
   parameter MS_CYCLES = 250000
) (
   input wire        pclk,
   input wire        presetn,
   input wire [20:0] sel_in,
   input wire        feed_coarse_out,
   input wire        feed_fine_out,
   input wire        fill_gate_out,
   input wire        empty_gate_out,
   input wire        bag_holder_out,
   input wire        active_member_out,
   input wire        weight_valid_out
);
   // A raw level counts as settled after 300 steady cycles, safely past the 252 cycle qualifier.
   wire [20:0] hi_s;
   wire [20:0] lo_s;
   genvar g;
   generate
      for (g = 0; g < 21; g = g + 1) begin : g_cnt
         reg [8:0] hi_q;
         reg [8:0] lo_q;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               hi_q <= 9'h000;
               lo_q <= 9'h000;
            end else begin
               hi_q <= !sel_in[g] ? 9'h000 : (hi_q == 9'h1FF) ? hi_q : hi_q + 9'h001;
               lo_q <= sel_in[g] ? 9'h000 : (lo_q == 9'h1FF) ? lo_q : lo_q + 9'h001;
            end
         end
         assign hi_s[g] = (hi_q >= 9'h12C);
         assign lo_s[g] = (lo_q >= 9'h12C);
      end
   endgenerate
   //////////////////////////////
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_run_low;
      lo_s[1] && lo_s[8] |-> !feed_coarse_out && !feed_fine_out;
   endproperty
   a_run_low: assert property (p_run_low) else $error("feed with run enable low");
   property p_inhibit;
      hi_s[2] && lo_s[5] && lo_s[6] && lo_s[8] |-> !$rose(fill_gate_out);
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("fill began while inhibited");
   property p_interrupt;
      hi_s[5] |-> !feed_coarse_out && !feed_fine_out;
   endproperty
   a_interrupt: assert property (p_interrupt) else $error("feed during interrupt");
   property p_hold;
      hi_s[6] |-> !feed_coarse_out && $stable(fill_gate_out) && $stable(empty_gate_out);
   endproperty
   a_hold: assert property (p_hold) else $error("outputs moved during hold");
   property p_two_hand;
      hi_s[9] && hi_s[10] && lo_s[16] && hi_s[17] && lo_s[6] |-> bag_holder_out;
   endproperty
   a_two_hand: assert property (p_two_hand) else $error("bag holder not closed");
   property p_release;
      (hi_s[16] || lo_s[17]) && lo_s[6] |-> !bag_holder_out;
   endproperty
   a_release: assert property (p_release) else $error("bag clamp not released");
   property p_tilt;
      hi_s[11] && lo_s[6] |-> !weight_valid_out;
   endproperty
   a_tilt: assert property (p_tilt) else $error("weight valid while tilted");
   property p_standby;
      hi_s[12] && lo_s[6] |-> !active_member_out;
   endproperty
   a_standby: assert property (p_standby) else $error("active while on standby");
endmodule
bind filler_selectable_io_control filler_io_properties #(.W(W), .MS_CYCLES(MS_CYCLES)) u_props (
   .pclk(pclk), .presetn(presetn), .sel_in(sel_in), .feed_coarse_out(feed_coarse_out),
   .feed_fine_out(feed_fine_out), .fill_gate_out(fill_gate_out), .empty_gate_out(empty_gate_out),
   .bag_holder_out(bag_holder_out), .active_member_out(active_member_out),
   .weight_valid_out(weight_valid_out));

//--- verif/scale_model.sv
// Behavioural scale that gains weight while feeding and loses it while emptying.
`timescale 1ns/1ps
module scale_model (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        feed_coarse,
   input  wire        feed_fine,
   input  wire        empty_gate,
   output reg  [23:0] gross_load
);
   // Coarse steps of three make a target that is not a multiple of three overshoot.
   wire [23:0] fed = gross_load + (feed_coarse ? 24'h000003 : (feed_fine ? 24'h000001 : 24'h000000));
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gross_load <= 24'h000000;
      end else if (empty_gate) begin
         gross_load <= (fed > 24'h000003) ? fed - 24'h000003 : 24'h000000;
      end else begin
         gross_load <= fed;
      end
   end
endmodule

//--- verif/test_filler_selectable_io_control.sv
// Self-checking bench for the selectable I/O controller.
`timescale 1ns/1ps
module test_filler_selectable_io_control;
   reg         pclk = 1'b0;
   reg         presetn = 1'b0;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [7:0]  paddr = 8'h00;
   reg  [31:0] pwdata = 32'h0000_0000;
   reg  [20:0] sel_in = 21'h020000;
   wire [31:0] prdata;
   wire        pready;
   wire        pslverr;
   wire [23:0] gross_load;
   wire [8:0]  outs;
   reg  [31:0] rd;
   reg         err;
   reg  [29:0] rows [0:8];
   reg  [24:0] blk = {5'h01, 5'h02, 5'h05, 5'h0C, 5'h0F};
   integer     fail_count = 0;
   integer     n_compared = 0;
   integer     i;
   integer     k;
   always #2 pclk = ~pclk;
   filler_selectable_io_control #(.W(24), .MS_CYCLES(10)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sel_in(sel_in),
      .gross_load(gross_load), .feed_coarse_out(outs[8]), .feed_fine_out(outs[7]), .fill_gate_out(outs[6]),
      .empty_gate_out(outs[5]), .bag_holder_out(outs[4]), .alarm_out(outs[3]), .sel_out1(outs[2]),
      .active_member_out(outs[1]), .weight_valid_out(outs[0]));
   scale_model partner (.pclk(pclk), .presetn(presetn), .feed_coarse(outs[8]), .feed_fine(outs[7]),
      .empty_gate(outs[5]), .gross_load(gross_load));
   //////////////////////////////
   task check(input [31:0] seen, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task apb(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task rdchk(input [7:0] a, input [31:0] exp);
      begin
         apb(1'b0, a, 32'h0000_0000);
         check(rd, exp);
      end
   endtask
   // Inputs qualify in 252 cycles; the margin also opens the checker's 300-cycle settle window.
   task wait_q;
      repeat (320) @(posedge pclk);
   endtask
   task pulse(input integer b);
      begin
         @(posedge pclk);
         sel_in[b] <= 1'b1;
         wait_q;
         sel_in[b] <= 1'b0;
         wait_q;
      end
   endtask
   task wait_st(input [5:0] st);
      begin
         k = 0;
         rd = 32'h0000_0000;
         while (rd[5:0] !== st && k < 1500) begin
            apb(1'b0, 8'h2C, 32'h0000_0000);
            k = k + 1;
         end
         check({26'h0, rd[5:0]}, {26'h0, st});
      end
   endtask
   task report_and_stop;
      begin
         $display("compared %0d, mismatches %0d", n_compared, fail_count);
         if (fail_count == 0 && n_compared > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   //////////////////////////////
   initial begin
      repeat (40000) @(posedge pclk);
      fail_count = fail_count + 1;
      report_and_stop;
   end
   initial begin
      rows[0] = {21'h020000, 9'h003};
      rows[1] = {21'h020600, 9'h013};
      rows[2] = {21'h020200, 9'h003};
      rows[3] = {21'h030600, 9'h003};
      rows[4] = {21'h000600, 9'h003};
      rows[5] = {21'h020800, 9'h002};
      rows[6] = {21'h021000, 9'h001};
      rows[7] = {21'h020080, 9'h023};
      rows[8] = {21'h020100, 9'h163};
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 9; i = i + 1) begin
         @(posedge pclk);
         sel_in <= rows[i][29:9];
         wait_q;
         check({23'h0, outs & 9'h173}, {23'h0, rows[i][8:0]});
      end
      $display("test rows done");
      sel_in <= 21'h020002;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      check({23'h0, outs}, 32'h0000_0000);
      presetn <= 1'b1;
      rdchk(8'h00, 32'h0000_0002);
      rdchk(8'h04, 32'h001F_FFFF);
      rdchk(8'h10, 32'h0000_0001);
      rdchk(8'h3C, 32'h0000_0000);
      check({31'h0, err}, 32'h0000_0001);
      apb(1'b1, 8'h2C, 32'h0000_0001);
      check({31'h0, err}, 32'h0000_0001);
      $display("test reset done");
      apb(1'b1, 8'h14, 32'h0000_0BB9);
      apb(1'b1, 8'h18, 32'h0000_0007);
      apb(1'b1, 8'h0C, 32'h0000_01F4);
      apb(1'b1, 8'h20, 32'h0000_0005);
      pulse(14);
      rdchk(8'h2C, 32'h0000_0601);
      pulse(13);
      rdchk(8'h2C, 32'h0000_0501);
      pulse(0);
      wait_st(6'h04);
      check({30'h0, outs[3:2]}, 32'h0000_0002);
      apb(1'b1, 8'h00, 32'h0000_0003);
      repeat (2) @(posedge pclk);
      check({31'h0, outs[2]}, 32'h0000_0001);
      apb(1'b1, 8'h00, 32'h0000_0002);
      rdchk(8'h34, 32'h0000_0000);
      pulse(3);
      wait_st(6'h08);
      rdchk(8'h34, 32'h0000_0001);
      rdchk(8'h38, 32'h0000_0BBB);
      pulse(19);
      wait_st(6'h01);
      apb(1'b1, 8'h08, 32'h0000_0002);
      rdchk(8'h30, 32'h0000_0002);
      apb(1'b1, 8'h08, 32'h0000_0000);
      $display("test fill done");
      sel_in[0] <= 1'b1;
      wait_q;
      sel_in[6] <= 1'b1;
      wait_q;
      check({30'h0, outs[8], outs[6]}, 32'h0000_0001);
      sel_in[6] <= 1'b0;
      sel_in[0] <= 1'b0;
      wait_q;
      check({31'h0, outs[8]}, 32'h0000_0001);
      sel_in[5] <= 1'b1;
      wait_q;
      check({30'h0, outs[8:7]}, 32'h0000_0000);
      sel_in[5] <= 1'b0;
      wait_q;
      check({31'h0, outs[8]}, 32'h0000_0001);
      wait_st(6'h04);
      pulse(4);
      wait_st(6'h01);
      rdchk(8'h34, 32'h0000_0001);
      $display("test hold done");
      for (i = 0; i < 5; i = i + 1) begin
         @(posedge pclk);
         sel_in[blk[i*5 +: 5]] <= ~sel_in[blk[i*5 +: 5]];
         wait_q;
         pulse(0);
         // The rejected fill left the scale above the alarm setpoint.
         rdchk(8'h2C, 32'h0000_0D01);
         sel_in[blk[i*5 +: 5]] <= ~sel_in[blk[i*5 +: 5]];
         wait_q;
      end
      $display("test blocked done");
      report_and_stop;
   end
endmodule
